// ===== bench/ccs_charger_tb.sv
// Purpose: Self-checking bench for the charge controller
// Assumes: Shortened timers; APB master on ref_clk
// Notes: State is polled over APB, so waits are bounded by read count
`timescale 1ns/1ps
module ccs_charger_tb;
  import ccs_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  ccs_comp_type comp = '0;
  logic dis_pin = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] r;
  logic pready, pslverr, e, pin, oe_n, pout, sw_en, chg_en, trk, stb;
  logic [15:0] len;
  int failures = 0;
  int checked = 0;

  initial forever #20 ref_clk = ~ref_clk;

  ccs_charger #(
    .TRICKLE_CYC_P(40'd200),
    .SAFETY_CYC_P(40'd300),
    .RECHARGE_CYC_P(40'd20),
    .THERM_HALF_CYC_P(24'd2000),
    .BAD_HALF_CYC_P(24'd1500)
  ) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .comp_in(comp),
    .charger_disable_pin(dis_pin), .charge_status_output_in(pin),
    .charge_status_output_out(pout), .charge_status_output_oe_n(oe_n),
    .switcher_enable(sw_en), .charge_enable(chg_en),
    .trickle_current(trk), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  ccs_host_model host (
    .ref_clk(ref_clk), .oe_n(oe_n), .pin_out(pout), .pin(pin),
    .meas_len(len), .meas_stb(stb)
  );

  task stop_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task chk1(input logic got, input logic exp);
    chk({31'b0, got}, {31'b0, exp});
  endtask : chk1

  task tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      failures++;
      stop_test();
    end
  endtask : apb

  task wait_st(input logic [2:0] s);
    int n;
    for (n = 0; n < 500; n++) begin
      apb(1'b0, ADDR_STAT, 32'h0);
      if (r[2:0] === s) break;
    end
    chk({29'b0, r[2:0]}, {29'b0, s});
    if (n == 500) stop_test();
  endtask : wait_st

  // Waits for one low run of the given length on the status pin
  task duty(input logic [15:0] want);
    int n;
    logic ok;
    ok = 1'b0;
    for (n = 0; n < 20000 && !ok; n++) begin
      @(posedge ref_clk);
      if (stb === 1'b1 && len === want) ok = 1'b1;
    end
    chk1(ok, 1'b1);
    if (!ok) stop_test();
  endtask : duty

  initial begin
    tick(16);
    sys_rst <= 1'b0;
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(r & 32'h7F, 32'h40);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk1(e, 1'b1);
    chk(r, 32'h0);
    comp.lock_rise_ok <= 1'b1;
    comp.below_trickle <= 1'b1;
    wait_st(3'd1);
    chk1(sw_en, 1'b1);
    chk1(trk, 1'b1);
    chk1(oe_n, 1'b0);
    chk1(pout, 1'b0);
    // Pulled-low pin must read back low once through the synchroniser
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(r & 32'hFF, 32'h11);
    wait_st(3'd5);
    chk1(chg_en, 1'b0);
    duty(16'd89);
    duty(16'd624);
    comp.therm_hot <= 1'b1;
    duty(16'd44);
    duty(16'd669);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk1(r[5], 1'b1);
    comp.therm_grounded <= 1'b1;
    tick(8);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk1(r[5], 1'b0);
    comp.therm_hot <= 1'b0;
    comp.therm_grounded <= 1'b0;
    apb(1'b1, ADDR_CTRL, 32'h1);
    wait_st(3'd0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(r, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h0);
    wait_st(3'd1);
    comp.below_trickle <= 1'b0;
    wait_st(3'd2);
    chk1(trk, 1'b0);
    comp.therm_cold <= 1'b1;
    tick(6);
    chk1(chg_en, 1'b0);
    comp.therm_cold <= 1'b0;
    tick(6);
    chk1(chg_en, 1'b1);
    comp.at_float <= 1'b1;
    comp.below_c10 <= 1'b1;
    comp.in_current_limit <= 1'b1;
    wait_st(3'd3);
    tick(6);
    chk1(oe_n, 1'b0);
    comp.in_current_limit <= 1'b0;
    tick(6);
    chk1(oe_n, 1'b1);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(r & 32'hFF, 32'hD3);
    // Pause longer than the whole safety time; only a frozen timer survives
    comp.therm_hot <= 1'b1;
    tick(400);
    comp.therm_hot <= 1'b0;
    wait_st(3'd3);
    tick(200);
    comp.below_recharge <= 1'b1;
    tick(40);
    comp.below_recharge <= 1'b0;
    tick(200);
    wait_st(3'd3);
    wait_st(3'd4);
    chk1(chg_en, 1'b0);
    comp.below_recharge <= 1'b1;
    tick(10);
    comp.below_recharge <= 1'b0;
    tick(30);
    wait_st(3'd4);
    comp.at_float <= 1'b0;
    comp.below_trickle <= 1'b1;
    comp.below_recharge <= 1'b1;
    tick(40);
    comp.below_recharge <= 1'b0;
    wait_st(3'd1);
    comp.lock_fall_trip <= 1'b1;
    tick(6);
    chk1(sw_en, 1'b0);
    wait_st(3'd0);
    comp.lock_fall_trip <= 1'b0;
    wait_st(3'd1);
    chk1(sw_en, 1'b1);
    dis_pin <= 1'b1;
    wait_st(3'd0);
    dis_pin <= 1'b0;
    wait_st(3'd1);
    stop_test();
  end
endmodule : ccs_charger_tb

// ===== bench/ccs_host_model.sv
// Purpose: Host side of the status pin, pull-up plus duty meter
// Assumes: Pin is pulled up when released, sampled on ref_clk
// Notes: Reports each low run length when the pin returns high, except a run of exactly HALF_RUN cycles
`timescale 1ns/1ps
module ccs_host_model #(
  parameter int HALF_RUN = 357
) (
  input wire logic ref_clk,
  input wire logic oe_n,
  input wire logic pin_out,
  output logic pin,
  output logic [15:0] meas_len,
  output logic meas_stb
);
  logic [15:0] run = 16'h0000;
  // Released pin floats up through the pull-up resistor
  assign pin = oe_n ? 1'b1 : pin_out;
  always @(posedge ref_clk) begin
    meas_stb <= 1'b0;
    if (!pin) begin
      run <= run + 16'h0001;
    end else if (run != 16'h0000) begin
      run <= 16'h0000;
      // Half duty is seen at a phase change; skip it and measure again
      if (run != 16'(HALF_RUN)) begin
        meas_len <= run;
        meas_stb <= 1'b1;
      end
    end
  end
endmodule : ccs_host_model

// ===== logic/ccs_charger.sv
// Purpose: Charge cycle sequencing, timers and status pin encoding
// Assumes: Comparator results arrive asynchronously; APB master on ref_clk
// Notes: Analog loops act on charge_enable and trickle_current only
`timescale 1ns/1ps
module ccs_charger #(
  parameter logic [ccs_pkg::TIMER_W-1:0] TRICKLE_CYC_P =
    ccs_pkg::TIMER_W'(ccs_pkg::TRICKLE_CYC),
  parameter logic [ccs_pkg::TIMER_W-1:0] SAFETY_CYC_P =
    ccs_pkg::TIMER_W'(ccs_pkg::SAFETY_CYC),
  parameter logic [ccs_pkg::TIMER_W-1:0] RECHARGE_CYC_P =
    ccs_pkg::TIMER_W'(ccs_pkg::RECHARGE_CYC),
  parameter logic [ccs_pkg::BLINK_W-1:0] THERM_HALF_CYC_P =
    ccs_pkg::BLINK_W'(ccs_pkg::THERM_HALF_CYC),
  parameter logic [ccs_pkg::BLINK_W-1:0] BAD_HALF_CYC_P =
    ccs_pkg::BLINK_W'(ccs_pkg::BAD_HALF_CYC)
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire ccs_pkg::ccs_comp_type comp_in,
  input wire logic charger_disable_pin,
  input wire logic charge_status_output_in,
  output logic charge_status_output_out,
  output logic charge_status_output_oe_n,
  output logic switcher_enable,
  output logic charge_enable,
  output logic trickle_current,
  input wire logic [ccs_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import ccs_pkg::*;

  localparam int SYNC_W = $bits(ccs_comp_type) + 2;

  logic [SYNC_W-1:0] sync_q;
  ccs_comp_type s;
  logic dis_pin_s;
  logic pin_level_s;

  // Every comparator and pin passes two flops before use [RQ22]
  ccs_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .d({comp_in, charger_disable_pin, charge_status_output_in}),
    .q(sync_q)
  );

  assign s = ccs_comp_type'(sync_q[SYNC_W-1:2]);
  assign dis_pin_s = sync_q[1];
  assign pin_level_s = sync_q[0];

  function automatic logic [CARRIER_W-1:0] duty_cycles(input int n);
    duty_cycles = CARRIER_W'((n * CARRIER_CYC) / DUTY_DEN);
  endfunction : duty_cycles

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = (a == ADDR_CTRL) || (a == ADDR_STAT);
  endfunction : addr_mapped

  // Register state
  logic ctrl_dis;
  logic next_ctrl_dis;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  // Sequencer state
  ccs_state_type state;
  ccs_state_type next_state;
  logic [TIMER_W-1:0] trk_cnt;
  logic [TIMER_W-1:0] next_trk_cnt;
  logic [TIMER_W-1:0] saf_cnt;
  logic [TIMER_W-1:0] next_saf_cnt;
  logic [TIMER_W-1:0] rch_cnt;
  logic [TIMER_W-1:0] next_rch_cnt;
  logic next_switcher_enable;
  logic next_charge_enable;
  logic next_trickle_current;

  // Status pin state
  logic [CARRIER_W-1:0] car_cnt;
  logic [CARRIER_W-1:0] next_car_cnt;
  logic [BLINK_W-1:0] blink_cnt;
  logic [BLINK_W-1:0] next_blink_cnt;
  logic blink_phase;
  logic next_blink_phase;
  logic next_oe_n;

  logic active;
  logic temp_fault;
  logic rch_hit;
  logic released;
  logic fault_temp;
  logic fault_bad;

  // Effective disable ORs the pin with the register bit [RQ21]
  assign active = switcher_enable & ~(dis_pin_s | ctrl_dis);
  // Grounded thermistor masks both temperature comparators [RQ19]
  assign temp_fault = (s.therm_hot | s.therm_cold) & ~s.therm_grounded;
  // Qualifies only once the drop outlasts the filter window [RQ8]
  assign rch_hit = s.below_recharge && (rch_cnt == RECHARGE_CYC_P);
  // Current limit masks the one-tenth comparator [RQ12] [RQ16]
  assign released = (state == ST_OFF) || (state == ST_DONE) ||
                    ((state == ST_CV) && s.at_float && s.below_c10 &&
                     !s.in_current_limit);
  // Temperature pattern wins when both faults coexist [RQ23]
  assign fault_temp = temp_fault && (state != ST_OFF) &&
                      (state != ST_DONE);
  assign fault_bad = (state == ST_BADBAT) && !fault_temp;

  // Input switcher lockout with hysteresis; the drop trip wins
  always_comb begin
    next_switcher_enable = switcher_enable;
    if (s.lock_fall_trip) begin
      next_switcher_enable = 1'b0; // [RQ2]
    end else if (s.lock_rise_ok) begin
      next_switcher_enable = 1'b1; // [RQ1]
    end
  end

  // Recharge filter counts consecutive low cycles and saturates
  always_comb begin
    next_rch_cnt = '0;
    if (s.below_recharge) begin
      if (rch_cnt > RECHARGE_CYC_P) begin
        next_rch_cnt = rch_cnt;
      end else begin
        next_rch_cnt = rch_cnt + TIMER_W'(1); // [RQ8]
      end
    end
  end

  always_comb begin
    next_state = state;
    next_trk_cnt = trk_cnt;
    next_saf_cnt = saf_cnt;
    if (!active) begin
      // Lockout or disable restarts the cycle and clears the trickle and safety timers [RQ10]
      next_state = ST_OFF;
      next_trk_cnt = '0;
      next_saf_cnt = '0;
    end else begin
      case (state)
        ST_OFF: begin
          next_state = ST_TRICKLE;
          next_trk_cnt = '0;
          next_saf_cnt = '0;
        end
        ST_TRICKLE: begin
          if (!s.below_trickle) begin
            next_state = ST_CC; // [RQ5]
            next_trk_cnt = '0;
          end else if (trk_cnt >= TRICKLE_CYC_P) begin
            next_state = ST_BADBAT; // [RQ4]
          end else if (!temp_fault) begin
            next_trk_cnt = trk_cnt + TIMER_W'(1);
          end
        end
        ST_CC: begin
          if (s.at_float) begin
            next_state = ST_CV; // [RQ6]
            next_saf_cnt = '0;
          end
        end
        ST_CV: begin
          if (rch_hit) begin
            next_saf_cnt = '0; // [RQ9]
          end else if (saf_cnt >= SAFETY_CYC_P) begin
            next_state = ST_DONE; // [RQ7]
          end else if (!temp_fault) begin
            // Pausing for temperature also freezes the timer [RQ18]
            next_saf_cnt = saf_cnt + TIMER_W'(1);
          end
        end
        ST_DONE: begin
          if (rch_hit) begin
            next_state = ST_TRICKLE; // [RQ8]
            next_trk_cnt = '0;
            next_saf_cnt = '0;
          end
        end
        ST_BADBAT: begin
          next_state = ST_BADBAT;
        end
        default: begin
          next_state = ST_OFF;
        end
      endcase
    end
    // Charging pauses while a temperature fault stands [RQ17]
    next_charge_enable = ((next_state == ST_TRICKLE) ||
                          (next_state == ST_CC) ||
                          (next_state == ST_CV)) && !temp_fault;
    next_trickle_current = (next_state == ST_TRICKLE); // [RQ3]
  end

  // Carrier and blink generators for the fault patterns
  always_comb begin
    logic [BLINK_W-1:0] half;
    logic [CARRIER_W-1:0] thr;
    half = fault_temp ? THERM_HALF_CYC_P : BAD_HALF_CYC_P;
    thr = '0;
    next_car_cnt = car_cnt + CARRIER_W'(1);
    if (car_cnt >= CARRIER_W'(CARRIER_CYC - 1)) begin
      next_car_cnt = '0; // [RQ13]
    end
    next_blink_cnt = '0;
    next_blink_phase = 1'b0;
    if (fault_temp || fault_bad) begin
      next_blink_phase = blink_phase;
      next_blink_cnt = blink_cnt + BLINK_W'(1);
      if (blink_cnt >= half - BLINK_W'(1)) begin
        next_blink_cnt = '0;
        next_blink_phase = ~blink_phase; // [RQ13]
      end
    end
    if (fault_temp) begin
      thr = blink_phase ? duty_cycles(THERM_DUTY_HI) :
                          duty_cycles(THERM_DUTY_LO); // [RQ14]
    end else begin
      thr = blink_phase ? duty_cycles(BAD_DUTY_HI) :
                          duty_cycles(BAD_DUTY_LO); // [RQ15]
    end
    if (fault_temp || fault_bad) begin
      next_oe_n = !(car_cnt < thr);
    end else begin
      next_oe_n = released; // [RQ11] [RQ12]
    end
  end

  // APB slave: zero-wait access, read data prepared in the setup cycle
  always_comb begin
    next_ctrl_dis = ctrl_dis;
    next_pready = psel && !penable;
    next_prdata = '0;
    next_pslverr = psel && !penable && !addr_mapped(paddr);
    if (psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_CTRL: begin
          next_prdata[CTRL_DIS_BIT] = ctrl_dis;
        end
        ADDR_STAT: begin
          next_prdata[STAT_STATE_LSB +: 3] = state;
          next_prdata[STAT_SWEN_BIT] = switcher_enable;
          next_prdata[STAT_TEMP_BIT] = temp_fault;
          next_prdata[STAT_REL_BIT] = charge_status_output_oe_n;
          next_prdata[STAT_PIN_BIT] = pin_level_s;
        end
        default: begin
          next_prdata = '0;
        end
      endcase
    end
    if (psel && penable && pready && pwrite && (paddr == ADDR_CTRL)) begin
      next_ctrl_dis = pwdata[CTRL_DIS_BIT]; // [RQ21]
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_dis <= CTRL_DIS_RESET;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      state <= ST_OFF;
      trk_cnt <= '0;
      saf_cnt <= '0;
      rch_cnt <= '0;
      switcher_enable <= 1'b0;
      charge_enable <= 1'b0;
      trickle_current <= 1'b0;
      car_cnt <= '0;
      blink_cnt <= '0;
      blink_phase <= 1'b0;
      charge_status_output_oe_n <= 1'b1;
      charge_status_output_out <= 1'b0;
    end else begin
      ctrl_dis <= next_ctrl_dis;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      state <= next_state;
      trk_cnt <= next_trk_cnt;
      saf_cnt <= next_saf_cnt;
      rch_cnt <= next_rch_cnt;
      switcher_enable <= next_switcher_enable;
      charge_enable <= next_charge_enable;
      trickle_current <= next_trickle_current;
      car_cnt <= next_car_cnt;
      blink_cnt <= next_blink_cnt;
      blink_phase <= next_blink_phase;
      charge_status_output_oe_n <= next_oe_n;
      charge_status_output_out <= 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence charging_seq;
    active && !temp_fault && ((state == ST_TRICKLE) || (state == ST_CC));
  endsequence

  sequence cv_paused_seq;
    active && (state == ST_CV) && temp_fault && !rch_hit &&
    (saf_cnt < SAFETY_CYC_P);
  endsequence

  chk_lock_hold: assert property ( // [RQ1]
    !switcher_enable && !s.lock_rise_ok |=> !switcher_enable
  ) else $error("switcher enabled without supply good");

  chk_lock_drop: assert property ( // [RQ2]
    s.lock_fall_trip |=> !switcher_enable ##1 (state == ST_OFF)
  ) else $error("switcher not dropped on lockout trip");

  chk_trickle_cmd: assert property ( // [RQ3]
    (state == ST_TRICKLE) |-> trickle_current
  ) else $error("trickle current not commanded");

  chk_bad_timeout: assert property ( // [RQ4]
    active && (state == ST_TRICKLE) && s.below_trickle &&
    (trk_cnt >= TRICKLE_CYC_P) |=> (state == ST_BADBAT)
  ) else $error("bad battery timeout missed");

  chk_cc_entry: assert property ( // [RQ5]
    active && (state == ST_TRICKLE) && !s.below_trickle
    |=> (state == ST_CC) && !trickle_current
  ) else $error("constant current not entered");

  chk_cv_start: assert property ( // [RQ6]
    active && (state == ST_CC) && s.at_float
    |=> (state == ST_CV) && (saf_cnt == '0)
  ) else $error("float entry did not start safety timer");

  chk_done_off: assert property ( // [RQ7]
    (state == ST_DONE) |-> !charge_enable
  ) else $error("current delivered after termination");

  chk_recharge_filter: assert property ( // [RQ8]
    active && (state == ST_DONE) && !rch_hit |=> (state == ST_DONE)
  ) else $error("recharge started without filtered drop");

  chk_safety_clear: assert property ( // [RQ9]
    active && (state == ST_CV) && rch_hit |=> (saf_cnt == '0)
  ) else $error("safety timer not cleared by recharge drop");

  chk_restart_clear: assert property ( // [RQ10]
    !active |=> (state == ST_OFF) && (saf_cnt == '0) && (trk_cnt == '0)
  ) else $error("restart did not clear the cycle");

  chk_status_low: assert property ( // [RQ11]
    charging_seq |=> !charge_status_output_oe_n
  ) else $error("status not pulled low while charging");

  chk_temp_pause: assert property ( // [RQ17]
    temp_fault |=> !charge_enable
  ) else $error("charging not paused on temperature fault");

  chk_timer_freeze: assert property ( // [RQ18]
    cv_paused_seq |=> $stable(saf_cnt)
  ) else $error("safety timer ran during temperature pause");
endmodule : ccs_charger

// ===== logic/ccs_pkg.sv
// Purpose: Constants, types and field layouts for the charge controller
// Assumes: 25 MHz ref_clk, APB register access, 32-bit data
// Notes: Long timer counts are defaults for top-level parameters
// Behaviour
// RQ1: Keep input switcher off until lockout comparator reports supply good.
// RQ2: Turn input switcher off when the lockout drop comparator trips.
// RQ3: Command one-tenth charge current while battery is below trickle level.
// RQ4: Below trickle level over half an hour ends charging as bad battery.
// RQ5: Above trickle level, charge at full programmed constant current.
// RQ6: On reaching float voltage enter constant voltage, start safety timer.
// RQ7: Safety timer expiry stops charging and stays terminated.
// RQ8: After termination, recharge only after a filtered drop below 4.1V.
// RQ9: Filtered recharge drop clears a running safety timer.
// RQ10: Lockout or disable cycling restarts the charge and clears timers.
// RQ11: Status pin is pulled low throughout a normal charge cycle.
// RQ12: At float with current below one tenth, status pin is released.
// RQ13: Faults switch the status pin at 35kHz, duty alternating each half.
// RQ14: Temperature fault alternates 6.25% and 93.75% duty at 1.5Hz.
// RQ15: Bad battery fault alternates 12.5% and 87.5% duty at 6.1Hz.
// RQ16: Input current limit masks the one-tenth comparator for status.
// RQ17: Hot or cold thermistor comparator pauses charging until both clear.
// RQ18: Temperature pause in constant voltage also freezes the safety timer.
// RQ19: Grounded thermistor input disables temperature pausing and faults.
// RQ20: Host discards a duty reading of exactly one half and re-measures.
// RQ21: Effective disable is the pin ORed with the register bit.
// RQ22: All timing counts ref_clk cycles; comparator inputs are synchronised.
// RQ23: With both faults present, show the temperature fault pattern.
package ccs_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int CARRIER_HZ = 35_000;
  localparam int CARRIER_CYC = CLK_HZ / CARRIER_HZ;
  localparam int CARRIER_W = 10;
  localparam int DUTY_DEN = 16;
  localparam int THERM_DUTY_LO = 1;
  localparam int THERM_DUTY_HI = 15;
  localparam int BAD_DUTY_LO = 2;
  localparam int BAD_DUTY_HI = 14;
  localparam int THERM_BLINK_MHZ = 1500;
  localparam int BAD_BLINK_MHZ = 6100;
  localparam longint THERM_HALF_CYC =
    (longint'(CLK_HZ) * 1000) / (2 * THERM_BLINK_MHZ);
  localparam longint BAD_HALF_CYC =
    (longint'(CLK_HZ) * 1000) / (2 * BAD_BLINK_MHZ);
  localparam int BLINK_W = 24;
  localparam int TRICKLE_TIMEOUT_S = 1800;
  localparam int SAFETY_TIME_S = 14400;
  localparam int RECHARGE_FILTER_US = 1300;
  localparam longint TRICKLE_CYC = longint'(CLK_HZ) * TRICKLE_TIMEOUT_S;
  localparam longint SAFETY_CYC = longint'(CLK_HZ) * SAFETY_TIME_S;
  localparam longint RECHARGE_CYC =
    (longint'(CLK_HZ) * RECHARGE_FILTER_US + 999_999) / 1_000_000;
  localparam int TIMER_W = 40;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam int CTRL_DIS_BIT = 0;
  localparam logic CTRL_DIS_RESET = 1'b0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_SWEN_BIT = 4;
  localparam int STAT_TEMP_BIT = 5;
  localparam int STAT_REL_BIT = 6;
  localparam int STAT_PIN_BIT = 7;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_TRICKLE = 3'b001,
    ST_CC = 3'b010,
    ST_CV = 3'b011,
    ST_DONE = 3'b100,
    ST_BADBAT = 3'b101
  } ccs_state_type;

  typedef struct packed {
    logic lock_rise_ok;
    logic lock_fall_trip;
    logic below_trickle;
    logic at_float;
    logic below_recharge;
    logic below_c10;
    logic in_current_limit;
    logic therm_hot;
    logic therm_cold;
    logic therm_grounded;
  } ccs_comp_type;
endpackage : ccs_pkg

// ===== logic/ccs_sync.sv
// Purpose: Two-stage synchroniser for asynchronous level inputs
// Assumes: Inputs are slow levels relative to ref_clk
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module ccs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : ccs_sync
